// ---- common/hotswap_pkg.sv ----
// Constants, register map and types for the triple hot-swap sequencer
// Notes on behaviour
// - Polarity select sets every status output sense
// - Tracking/sequencing: any fault stops all channels
// - Independent: each channel follows only itself
// - Status asserts after successful start, never faulted
// - Startup pin open gives 9ms period
// - Resistor times 128 times 800pF sets period
// - Autoretry restarts after 64 startup periods
// - On low 100us clears latched fault, restarts
// - Slow comparator ignored during startup period
// - Mode input selects tracking, sequencing, independent
package hotswap_pkg;
  localparam int NUM_CH = 3;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LIVE = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFF_TIM_RES = 8'h10;

  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LATCH_BIT = 2;
  localparam int CTRL_POL_BIT = 3;
  localparam int CTRL_TIM_EXT_BIT = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RST = 5'h0d;
  localparam logic [1:0] MODE_INDEP = 2'h0;
  localparam logic [1:0] MODE_SEQ = 2'h1;
  localparam logic [1:0] MODE_TRACK = 2'h2;

  // Live state and interrupt layout
  localparam int LIVE_GATE_LSB = 0;
  localparam int LIVE_STAT_LSB = 3;
  localparam int IRQ_W = 6;
  localparam int IRQ_FAULT_LSB = 0;
  localparam int IRQ_GOOD_LSB = 3;

  // Timing resistor, in kilohm
  localparam int STARTUP_TIME_RESISTOR_W = 10;
  localparam logic [9:0] STARTUP_TIME_RESISTOR_MIN_K = 10'h004;
  localparam logic [9:0] STARTUP_TIME_RESISTOR_MAX_K = 10'h1f4;
  localparam logic [9:0] STARTUP_TIME_RESISTOR_RST_K = 10'h058;

  // Timing figures and derived cycle counts
  localparam int CLK_MHZ = 250;
  localparam int T_DEFAULT_US = 9000;
  localparam int T_UNLATCH_US = 100;
  localparam int TIM_SCALE = 128;
  localparam int TIM_UNIT_PF = 800;
  localparam int RETRY_SHIFT = 6;
  localparam int unsigned START_DEFAULT_CYC = T_DEFAULT_US * CLK_MHZ;
  localparam int unsigned UNLATCH_CYC = T_UNLATCH_US * CLK_MHZ;
  localparam int unsigned CYC_PER_KOHM = TIM_SCALE * TIM_UNIT_PF * CLK_MHZ / 1000;

  typedef enum logic [2:0] {CH_OFF, CH_START, CH_ON, CH_FAULT, CH_RETRY} ch_state_e;
endpackage

// ---- rtl/down_timer.sv ----
// Loadable down counter that stops at zero
`timescale 1ns/10ps
module down_timer (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic load, // Load strobe
  input wire logic [hotswap_pkg::CNT_W-1:0] load_val, // Value to load
  output logic [hotswap_pkg::CNT_W-1:0] count, // Remaining cycles
  output logic zero // Count has run out
);
  import hotswap_pkg::*;

  // Load wins over counting so a restart never sees a stale value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (load) begin
      count <= load_val;
    end else if (count != '0) begin
      count <= count - CNT_W'(1);
    end
  end

  assign zero = (count == '0);
endmodule

// ---- rtl/hotswap_seq.sv ----
// Triple-channel hot-swap sequencer with APB registers
`timescale 1ns/10ps
module hotswap_seq #(
  parameter int unsigned START_DEF = hotswap_pkg::START_DEFAULT_CYC,
  parameter int unsigned UNLATCH = hotswap_pkg::UNLATCH_CYC,
  parameter int unsigned PER_KOHM = hotswap_pkg::CYC_PER_KOHM
) (
  input wire logic pclk, // Clock, 250 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic [hotswap_pkg::ADDR_W-1:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [hotswap_pkg::DATA_W-1:0] pwdata, // APB write data
  output logic [hotswap_pkg::DATA_W-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [hotswap_pkg::NUM_CH-1:0] on_in, // Channel on requests
  input wire logic [hotswap_pkg::NUM_CH-1:0] slow_oc, // Slow comparator trips
  input wire logic [hotswap_pkg::NUM_CH-1:0] fast_oc, // Fast comparator trips
  output logic [hotswap_pkg::NUM_CH-1:0] gate_drive, // Gate drive enables
  output logic [hotswap_pkg::NUM_CH-1:0] stat_o, // Status pin output value
  output logic [hotswap_pkg::NUM_CH-1:0] stat_oe_n, // Status pin enable, low drives
  output logic irq // Level interrupt
);
  import hotswap_pkg::*;

  logic [CTRL_W-1:0] ctrl;
  logic [STARTUP_TIME_RESISTOR_W-1:0] tim_res;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] next_period;
  logic [STARTUP_TIME_RESISTOR_W-1:0] res_cl;
  logic [1:0] ctrl_mode;
  logic ctrl_latch;
  logic ctrl_pol;
  logic ctrl_tim_ext;
  logic indep;
  ch_state_e st [NUM_CH];
  ch_state_e next_st [NUM_CH];
  logic [NUM_CH-1:0] raw_f;
  logic [NUM_CH-1:0] flt_st;
  logic [NUM_CH-1:0] kill;
  logic grp_blk;
  logic [NUM_CH-1:0] tmr_ld;
  logic [CNT_W-1:0] tmr_val [NUM_CH];
  logic [CNT_W-1:0] tmr_cnt [NUM_CH];
  logic [NUM_CH-1:0] tmr_zero;
  logic [NUM_CH-1:0] stat_on;
  logic [NUM_CH-1:0] fault_evt;
  logic [NUM_CH-1:0] good_evt;
  logic setup_ph;
  logic wr_acc;
  logic hit;
  logic [DATA_W-1:0] rdata_c;

  assign ctrl_mode = ctrl[CTRL_MODE_LSB +: 2];
  assign ctrl_latch = ctrl[CTRL_LATCH_BIT];
  assign ctrl_pol = ctrl[CTRL_POL_BIT];
  assign ctrl_tim_ext = ctrl[CTRL_TIM_EXT_BIT];
  assign indep = (ctrl_mode == MODE_INDEP);

  // Resistor value is clamped to the usable range
  always_comb begin
    res_cl = tim_res;
    if (tim_res < STARTUP_TIME_RESISTOR_MIN_K) begin
      res_cl = STARTUP_TIME_RESISTOR_MIN_K;
    end else if (tim_res > STARTUP_TIME_RESISTOR_MAX_K) begin
      res_cl = STARTUP_TIME_RESISTOR_MAX_K;
    end
  end

  assign next_period = ctrl_tim_ext ? CNT_W'(res_cl) * CNT_W'(PER_KOHM) : CNT_W'(START_DEF);

  // Period is registered to keep the multiplier off the FSM path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period <= '0;
    end else begin
      period <= next_period;
    end
  end

  // Cross-channel fault terms; only ON channels can fault
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      // slow trips count only after startup
      raw_f[i] = (st[i] == CH_ON) && on_in[i] && (slow_oc[i] || fast_oc[i]);
      flt_st[i] = (st[i] == CH_FAULT) || (st[i] == CH_RETRY);
    end
  end

  assign grp_blk = !indep && ((|raw_f) || (|flt_st));

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gen_ch
      // independent mode uses own fault only
      assign kill[g] = indep ? raw_f[g] : (|raw_f);

      // Channel next state and timer loads
      always_comb begin
        next_st[g] = st[g];
        tmr_ld[g] = 1'b0;
        tmr_val[g] = period;
        case (st[g])
          CH_OFF: begin
            if (on_in[g] && !grp_blk) begin
              next_st[g] = CH_START;
              tmr_ld[g] = 1'b1;
            end
          end
          CH_START, CH_ON: begin
            if (!on_in[g]) begin
              next_st[g] = CH_OFF;
            end else if (kill[g] && ctrl_latch) begin
              next_st[g] = CH_FAULT;
              tmr_ld[g] = 1'b1;
              tmr_val[g] = CNT_W'(UNLATCH);
            end else if (kill[g]) begin
              next_st[g] = CH_RETRY;
              tmr_ld[g] = 1'b1;
              tmr_val[g] = period << RETRY_SHIFT;
            end else if (st[g] == CH_START && tmr_zero[g]) begin
              next_st[g] = CH_ON;
            end
          end
          CH_FAULT: begin
            // on held low clears the latch
            if (on_in[g]) begin
              tmr_ld[g] = 1'b1;
              tmr_val[g] = CNT_W'(UNLATCH);
            end else if (tmr_zero[g]) begin
              next_st[g] = CH_OFF;
            end
          end
          CH_RETRY: begin
            if (tmr_zero[g]) begin
              next_st[g] = CH_START;
              tmr_ld[g] = 1'b1;
            end
          end
          default: begin
            next_st[g] = CH_OFF;
          end
        endcase
      end

      // Channel state register
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st[g] <= CH_OFF;
        end else begin
          st[g] <= next_st[g];
        end
      end

      down_timer u_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .load(tmr_ld[g]),
        .load_val(tmr_val[g]),
        .count(tmr_cnt[g]),
        .zero(tmr_zero[g])
      );

      assign fault_evt[g] = (next_st[g] == CH_FAULT || next_st[g] == CH_RETRY) && !flt_st[g];
      assign good_evt[g] = (st[g] == CH_START) && (next_st[g] == CH_ON);

      // Pin outputs come straight from flops to avoid glitches
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gate_drive[g] <= 1'b0;
          stat_on[g] <= 1'b0;
          stat_oe_n[g] <= 1'b0;
        end else begin
          gate_drive[g] <= (next_st[g] == CH_START) || (next_st[g] == CH_ON);
          stat_on[g] <= (next_st[g] == CH_ON);
          // polarity picks which state releases the pin
          stat_oe_n[g] <= ctrl_pol ? (next_st[g] == CH_ON) : (next_st[g] != CH_ON);
        end
      end
    end
  endgenerate

  // Status pins are open drain and only ever pull low
  assign stat_o = '0;

  // APB phase decode; slave never inserts wait states
  assign pready = 1'b1;
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite && hit;

  // Address decode and read mux
  always_comb begin
    hit = 1'b1;
    rdata_c = '0;
    if (paddr == OFF_CTRL) begin
      rdata_c[CTRL_W-1:0] = ctrl;
    end else if (paddr == OFF_LIVE) begin
      rdata_c[LIVE_GATE_LSB +: NUM_CH] = gate_drive;
      rdata_c[LIVE_STAT_LSB +: NUM_CH] = stat_on;
    end else if (paddr == OFF_IRQ_STAT) begin
      rdata_c[IRQ_W-1:0] = irq_stat;
    end else if (paddr == OFF_IRQ_MASK) begin
      rdata_c[IRQ_W-1:0] = irq_mask;
    end else if (paddr == OFF_TIM_RES) begin
      rdata_c[STARTUP_TIME_RESISTOR_W-1:0] = tim_res;
    end else begin
      hit = 1'b0;
    end
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= pwrite ? '0 : rdata_c;
      pslverr <= !hit;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      tim_res <= STARTUP_TIME_RESISTOR_RST_K;
      irq_mask <= '0;
    end else if (wr_acc) begin
      if (paddr == OFF_CTRL) begin
        ctrl <= pwdata[CTRL_W-1:0];
      end else if (paddr == OFF_TIM_RES) begin
        tim_res <= pwdata[STARTUP_TIME_RESISTOR_W-1:0];
      end else if (paddr == OFF_IRQ_MASK) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_acc && paddr == OFF_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0))
                  | {good_evt, fault_evt};
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // Checks on channels 0 and 1 and on shared logic
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_retry_done;
    st[0] == CH_RETRY && tmr_zero[0];
  endsequence

  sequence s_restart;
    st[0] == CH_START ##0 tmr_cnt[0] == period;
  endsequence

  property p_pol;
    stat_oe_n[0] == ((st[0] == CH_ON) == $past(ctrl_pol));
  endproperty
  a_pol: assert property (p_pol) else $error("status pin sense wrong");

  property p_group_off;
    (!indep && (|raw_f)) |=> gate_drive == '0;
  endproperty
  a_group_off: assert property (p_group_off) else $error("group fault left a gate on");

  property p_indep_keep;
    (indep && raw_f[0] && st[1] == CH_ON && on_in[1] && !slow_oc[1] && !fast_oc[1]) |=> gate_drive[1];
  endproperty
  a_indep_keep: assert property (p_indep_keep) else $error("healthy channel was stopped");

  property p_stat_after_start;
    $rose(stat_on[0]) |-> $past(st[0] == CH_START && tmr_zero[0]);
  endproperty
  a_stat_after_start: assert property (p_stat_after_start) else $error("status rose early");

  property p_default_period;
    !ctrl_tim_ext |=> period == CNT_W'(START_DEF);
  endproperty
  a_default_period: assert property (p_default_period) else $error("default period wrong");

  property p_res_period;
    (ctrl_tim_ext && tim_res >= STARTUP_TIME_RESISTOR_MIN_K && tim_res <= STARTUP_TIME_RESISTOR_MAX_K)
      |=> period == CNT_W'($past(tim_res)) * CNT_W'(PER_KOHM);
  endproperty
  a_res_period: assert property (p_res_period) else $error("resistor period wrong");

  property p_retry_load;
    (raw_f[0] && !ctrl_latch) |=> st[0] == CH_RETRY && tmr_cnt[0] == ($past(period) << RETRY_SHIFT);
  endproperty
  a_retry_load: assert property (p_retry_load) else $error("retry delay not loaded");

  property p_retry_restart;
    s_retry_done |=> s_restart;
  endproperty
  a_retry_restart: assert property (p_retry_restart) else $error("retry did not restart");

  property p_unlatch;
    (st[0] == CH_FAULT && on_in[0]) ##1 (!on_in[0])[*1]
      |-> tmr_cnt[0] == CNT_W'(UNLATCH) ##0 st[0] == CH_FAULT;
  endproperty
  a_unlatch: assert property (p_unlatch) else $error("unlatch wait not restarted");

  property p_unlatch_done;
    (st[0] == CH_FAULT && !on_in[0] && tmr_zero[0]) |=> st[0] == CH_OFF;
  endproperty
  a_unlatch_done: assert property (p_unlatch_done) else $error("latch not cleared");

  // A slow trip in startup on channel 0 alone must not fault it
  property p_slow_ignored;
    (st[0] == CH_START && on_in[0] && slow_oc[0] && raw_f[NUM_CH-1:1] == '0) |=> !flt_st[0];
  endproperty
  a_slow_ignored: assert property (p_slow_ignored) else $error("fault taken in startup");

  property p_mode_indep;
    indep |-> kill == raw_f;
  endproperty
  a_mode_indep: assert property (p_mode_indep) else $error("mode coupling wrong");
endmodule

// ---- test/hs_power_stage.sv ----
// Far-side model: external MOSFETs and sense resistors of three channels
`timescale 1ns/10ps
module hs_power_stage (
  input wire logic pclk, // Clock
  input wire logic [2:0] gate_drive, // Gate enables from the block
  input wire logic [2:0] trip_slow, // Bench orders a slow overload
  input wire logic [2:0] trip_fast, // Bench orders a hard short
  output logic [2:0] slow_oc, // Slow comparator trips
  output logic [2:0] fast_oc // Fast comparator trips
);
  logic [1:0] age [3];
  // Board capacitance pulls inrush for a few edges after each turn-on
  always_ff @(posedge pclk) begin
    for (int i = 0; i < 3; i++) begin
      if (!gate_drive[i]) begin
        age[i] <= 2'h0;
      end else if (age[i] != 2'h3) begin
        age[i] <= age[i] + 2'h1;
      end
    end
  end
  // An off MOSFET carries no current, so it never shows a trip
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      slow_oc[i] = gate_drive[i] & trip_slow[i];
      fast_oc[i] = gate_drive[i] & (trip_fast[i] | (age[i] != 2'h3));
    end
  end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the triple hot-swap sequencer
`timescale 1ns/10ps
module tb_top;
  import hotswap_pkg::*;
  localparam int unsigned SD = 40;
  localparam int unsigned UL = 20;
  localparam int unsigned PK = 2;
  typedef struct {string what; logic [32:0] val;} exp_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic [2:0] on_in = 3'h0;
  logic [2:0] trip_slow = 3'h0;
  logic [2:0] trip_fast = 3'h0;
  logic [2:0] slow_oc, fast_oc, gate_drive, stat_o, stat_oe_n;
  logic status_polarity_sel = 1'b1;
  int n_mismatch = 0;
  int n_compared = 0;
  exp_s expq[$];
  // Bus clock, 4 ns period
  always #2 pclk = ~pclk;
  // Short counts keep the run brief; expectations use the same values
  hotswap_seq #(.START_DEF(SD), .UNLATCH(UL), .PER_KOHM(PK)) dut (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .on_in, .slow_oc, .fast_oc, .gate_drive, .stat_o, .stat_oe_n, .irq);
  hs_power_stage load (.pclk, .gate_drive, .trip_slow, .trip_fast, .slow_oc, .fast_oc);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    // A read note left unanswered means a read never completed
    if (expq.size() != 0) begin
      n_mismatch++;
    end
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Status asserted per channel, whatever the selected polarity
  function automatic logic [2:0] up();
    return status_polarity_sel ? stat_oe_n : ~stat_oe_n;
  endfunction
  // One APB transfer; starts on a rising edge, request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input string what);
    expq.push_back('{what, e});
    apb(a, 1'b0, 32'h0);
  endtask
  // Read monitor: pairs each finished read with the oldest note
  always @(posedge pclk) begin
    exp_s e;
    if (psel && penable && pready && !pwrite && expq.size() > 0) begin
      e = expq.pop_front();
      check(e.what, {31'h0, pslverr}, {31'h0, e.val[32]});
      check(e.what, prdata, e.val[31:0]);
    end
  end
  task automatic wait_gate(input logic [2:0] e, input int lim);
    int k;
    k = 0;
    #1;
    while (gate_drive !== e && k < lim) begin
      @(posedge pclk);
      #1;
      k++;
    end
    check("gate", gate_drive, e);
    if (gate_drive !== e) begin
      complete_run();
    end
  endtask
  // Turn all channels on and time the startup period
  task automatic start_all(input int per);
    int n;
    tick(1);
    on_in <= 3'h7;
    wait_gate(3'h7, 5);
    n = 0;
    while (up() !== 3'h7 && n < per + 10) begin
      @(posedge pclk);
      // Slow trips end on an edge while the channels still start
      if (n == 7) begin
        trip_slow <= 3'h0;
      end
      #1;
      n++;
    end
    check("startup cycles", n, per + 1);
    check("stat_o", stat_o, 32'h0);
    if (n >= per + 10) begin
      complete_run();
    end
  endtask
  initial begin
    int ch;
    int n;
    void'($urandom(52));
    tick(20);
    presetn <= 1'b1;
    tick(3);
    rd(OFF_CTRL, 33'h0000000d, "ctrl");
    rd(OFF_IRQ_MASK, 33'h0, "mask");
    rd(OFF_TIM_RES, 33'h00000058, "tim_res");
    rd(8'h14, 33'h100000000, "unmapped");
    apb(OFF_LIVE, 1'b1, 32'h3f);
    rd(OFF_LIVE, 33'h0, "live");
    #1;
    check("idle stat", stat_oe_n, 32'h0);
    // Slow trips during startup must be ignored; inrush trips the fast one
    tick(1);
    trip_slow <= 3'h7;
    start_all(SD);
    rd(OFF_LIVE, 33'h3f, "live on");
    #1;
    check("irq masked", irq, 32'h0);
    apb(OFF_IRQ_MASK, 1'b1, 32'h3f);
    #1;
    check("irq", irq, 32'h1);
    apb(OFF_IRQ_STAT, 1'b1, 32'h3f);
    #1;
    check("irq cleared", irq, 32'h0);
    // A fault on one channel stops the whole group
    ch = $urandom % 3;
    tick(1);
    trip_slow <= 3'(1 << ch);
    wait_gate(3'h0, 5);
    check("group stat", up(), 32'h0);
    check("irq fault", irq, 32'h1);
    tick(1);
    trip_slow <= 3'h0;
    apb(OFF_IRQ_STAT, 1'b1, 32'h3f);
    tick(60);
    #1;
    check("latched", gate_drive, 32'h0);
    // short low is too brief to unlatch
    tick(1);
    on_in <= 3'h0;
    tick(5);
    on_in <= 3'h7;
    tick(10);
    #1;
    check("short unlatch", gate_drive, 32'h0);
    // on held low past the unlatch time
    tick(1);
    on_in <= 3'h0;
    tick(UL + 5);
    apb(OFF_CTRL, 1'b1, 32'h0e);
    start_all(SD);
    tick(1);
    trip_fast <= 3'h4;
    wait_gate(3'h0, 5);
    tick(1);
    trip_fast <= 3'h0;
    on_in <= 3'h0;
    tick(UL + 5);
    // Independent, autoretry, low polarity, resistor-set period
    apb(OFF_TIM_RES, 1'b1, 32'h4);
    apb(OFF_CTRL, 1'b1, 32'h10);
    status_polarity_sel = 1'b0;
    tick(2);
    #1;
    check("idle stat low pol", stat_oe_n, 32'h7);
    start_all(4 * PK);
    check("on stat low pol", stat_oe_n, 32'h0);
    ch = $urandom % 3;
    tick(1);
    trip_slow <= 3'(1 << ch);
    wait_gate(~3'(1 << ch), 5);
    check("indep stat", up(), {29'h0, ~3'(1 << ch)});
    tick(1);
    trip_slow <= 3'h0;
    n = 0;
    while (gate_drive !== 3'h7 && n < 600) begin
      @(posedge pclk);
      #1;
      n++;
    end
    // Counted from the second edge after the gate fell: exactly 64 periods
    check("retry delay", n, 64 * 4 * PK);
    complete_run();
  end
  // Watchdog against a hang
  initial begin
    tick(100000);
    n_mismatch++;
    complete_run();
  end
endmodule
